// ==== sbc_core.sv ====
// Purpose: Command interpreter for miscellaneous, standards and gauge commands, plus scan-side correction.
// Assumes: Command bytes arrive as one-cycle strobes from the board handshake on the same clock.
// Notes:   All state except the reset synchroniser and busy_cyc lives in one struct; responses are shifted out high byte first.
`timescale 1ns/1ps

// Contract
// R1 - Bytes 240,5,0 return firmware version times 100, high byte first.
// R2 - Opcode 64 returns signed reference temperature, 0.1 C per count, high first.
// R3 - Without a reference sensor the two temperature bytes still come, meaningless.
// R4 - Bytes 240,4,0 return the 16-bit model identity, high byte first.
// R5 - Standards calibration is 224+channel, selector, then reference word high first.
// R6 - Selector 0 is 5 V, 1 is 500 mV, 2 is the resistance standard.
// R7 - A finished standards calibration returns exactly one don't-care byte.
// R8 - Host calibrates 5 V, then 500 mV, then the resistance standard.
// R9 - New standard takes effect only after reset; reset between calibrations.
// R10 - Cold junction is measured periodically; compensation computed for every type.
// R11 - Thermocouple voltage gets compensation added before conversion.
// R12 - Gauge excitation only while that gauge channel is scanned.
// R13 - Reset discards every gauge zero and span calibration.
// R14 - Opcode 176+channel records the present reading as the gauge zero.
// R15 - Opcode 208+channel plus word scales so the present load gives that word.
// R16 - After tare, the stored tare is subtracted from every later gross reading.
// R17 - Calibration read back may be written back to restore a gauge.
// R18 - Each command completes within 30 us, handshake excluded.
// R19 - A selector above 2 is ignored and stores no standard.
module sbc_core
    import sbc_pkg::*;
#(
    parameter logic [15:0] FW_VERSION = 16'h0064,
    parameter logic [15:0] MODEL_ID   = 16'h1234,
    parameter int unsigned CJ_PERIOD  = CJ_PERIOD_DEF
)(
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  cmd_valid_in,
    input  wire logic [7:0]            cmd_byte_in,
    output logic                       cmd_ready_out,
    output logic                       resp_valid_out,
    output logic [7:0]                 resp_byte_out,
    input  wire logic                  resp_ack_in,
    input  wire logic [15:0]           cj_temp_in,
    input  wire logic                  cj_valid_in,
    output logic                       cj_req_out,
    input  wire logic [7:0]            gauge_mask_in,
    input  wire logic [7:0]            tc_mask_in,
    input  wire logic [7:0][3:0]       tc_type_in,
    input  wire logic                  scan_active_in,
    input  wire logic [2:0]            scan_chan_in,
    input  wire logic                  sample_valid_in,
    input  wire logic [2:0]            sample_chan_in,
    input  wire logic [15:0]           sample_raw_in,
    output logic [7:0]                 excite_out,
    output logic                       tc_valid_out,
    output logic [2:0]                 tc_chan_out,
    output logic [15:0]                tc_volt_out,
    output logic                       gauge_valid_out,
    output logic [2:0]                 gauge_chan_out,
    output logic [15:0]                gauge_data_out,
    output logic                       std_write_out,
    output logic [1:0]                 std_sel_out,
    output logic [2:0]                 std_chan_out,
    output logic [15:0]                std_value_out
);

    logic [1:0]   rst_sync_ff;
    logic         rst_n;
    sbc_state_s   st_ff;
    sbc_state_s   nxt_st;

    // Release is synchronised so all flops leave reset on the same edge
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    function automatic logic [15:0] gross_of(input logic [15:0] raw, input logic [15:0] zr,
                                             input logic [15:0] gn);
        logic signed [16:0] diff;
        logic signed [33:0] prod;
        diff = $signed({raw[15], raw}) - $signed({zr[15], zr});
        prod = diff * $signed({gn[15], gn});
        return prod[GAIN_FRAC +: 16];
    endfunction

    always_comb
    begin
        logic [15:0]        expect_w;
        logic signed [16:0] delta;
        logic [16:0]        delta_abs;
        logic [16:0]        rem2;
        logic [2:0]         ch;
        logic [7:0]         b;
        logic signed [31:0] cprod;
        logic [15:0]        qsat;
        expect_w  = 16'h0000;
        delta     = 17'sh00000;
        delta_abs = 17'h00000;
        rem2      = 17'h00000;
        ch        = st_ff.op[2:0];
        b         = cmd_byte_in;
        cprod     = 32'sh00000000;
        qsat      = 16'h0000;
        nxt_st    = st_ff;
        nxt_st.std_write = 1'b0;
        nxt_st.tc_valid  = 1'b0;
        nxt_st.g_valid   = 1'b0;
        nxt_st.cj_req    = 1'b0;

        // Periodic cold-junction request and refresh of every type's compensation
        if (st_ff.cj_timer == 16'(CJ_PERIOD - 1))
        begin
            nxt_st.cj_timer = 16'h0000;
            nxt_st.cj_req   = 1'b1; // R10
        end
        else
            nxt_st.cj_timer = st_ff.cj_timer + 16'h0001;
        if (cj_valid_in)
        begin
            for (int t = 0; t < NUM_TC_TYPES; t++)
            begin
                cprod = $signed(cj_temp_in) * $signed(SEEBECK_DEF);
                nxt_st.comp[t] = cprod[GAIN_FRAC +: 16]; // R10
            end
        end

        for (int i = 0; i < NUM_CHAN; i++)
            nxt_st.excite[i] = scan_active_in && (scan_chan_in == 3'(i)) && gauge_mask_in[i]; // R12

        if (sample_valid_in)
        begin
            if (tc_mask_in[sample_chan_in])
            begin
                nxt_st.tc_valid = 1'b1;
                nxt_st.tc_chan  = sample_chan_in;
                nxt_st.tc_volt  = sample_raw_in + st_ff.comp[tc_type_in[sample_chan_in]]; // R11
            end
            if (gauge_mask_in[sample_chan_in])
            begin
                nxt_st.last_raw[sample_chan_in] = sample_raw_in;
                nxt_st.g_valid = st_ff.cal_ok[sample_chan_in];
                nxt_st.g_chan  = sample_chan_in;
                nxt_st.g_data  = gross_of(sample_raw_in, st_ff.zero[sample_chan_in],
                                          st_ff.gain[sample_chan_in]) - st_ff.tare[sample_chan_in]; // R16
            end
        end

        unique case (st_ff.state)
            SBC_IDLE:
            begin
                if (cmd_valid_in)
                begin
                    nxt_st.op   = b;
                    ch          = b[2:0];
                    if (b == OP_EXT_PREFIX)
                    begin
                        nxt_st.need  = ARGS_EXT;
                        nxt_st.state = SBC_ARGS;
                    end
                    else if (b == OP_REF_TEMP)
                    begin
                        // Reply is sent even with no sensor attached, so the host never hangs
                        nxt_st.resp      = {cj_temp_in, 32'h00000000}; // R2 R3
                        nxt_st.resp_left = RESP_WORD;
                        nxt_st.state     = SBC_RESP;
                    end
                    else if (b[7:3] == OP_STD_CAL[7:3])
                    begin
                        nxt_st.need  = ARGS_STD_CAL; // R5
                        nxt_st.state = SBC_ARGS;
                    end
                    else if (b[7:3] == OP_GAUGE_SPAN[7:3])
                    begin
                        nxt_st.need  = ARGS_SPAN; // R15
                        nxt_st.state = SBC_ARGS;
                    end
                    else if (b[7:3] == OP_CAL_RESTORE[7:3])
                    begin
                        nxt_st.need  = ARGS_RESTORE; // R17
                        nxt_st.state = SBC_ARGS;
                    end
                    else if (b[7:3] == OP_GAUGE_ZERO[7:3])
                    begin
                        nxt_st.zero[ch]   = nxt_st.last_raw[ch]; // R14
                        nxt_st.tare[ch]   = 16'h0000;
                        nxt_st.cal_ok[ch] = 1'b0;
                    end
                    else if (b[7:3] == OP_TARE[7:3])
                    begin
                        if (st_ff.cal_ok[ch])
                            nxt_st.tare[ch] = gross_of(st_ff.last_raw[ch], st_ff.zero[ch], st_ff.gain[ch]); // R16
                    end
                    else if (b[7:3] == OP_CAL_READBACK[7:3])
                    begin
                        nxt_st.resp      = {st_ff.zero[ch], st_ff.gain[ch], st_ff.tare[ch]}; // R17
                        nxt_st.resp_left = RESP_CAL_DATA;
                        nxt_st.state     = SBC_RESP;
                    end
                end
            end
            SBC_ARGS:
            begin
                if (cmd_valid_in)
                begin
                    nxt_st.args = {st_ff.args[31:0], b};
                    nxt_st.need = st_ff.need - 3'h1;
                    if (st_ff.need == 3'h1)
                    begin
                        nxt_st.state = SBC_IDLE;
                        if (st_ff.op == OP_EXT_PREFIX)
                        begin
                            // Unknown sub-codes or a bad trailer are dropped silently
                            if (b == EXT_TRAILER && st_ff.args[7:0] == SUB_FIRMWARE)
                            begin
                                nxt_st.resp      = {FW_VERSION, 32'h00000000}; // R1
                                nxt_st.resp_left = RESP_WORD;
                                nxt_st.state     = SBC_RESP;
                            end
                            else if (b == EXT_TRAILER && st_ff.args[7:0] == SUB_MODEL)
                            begin
                                nxt_st.resp      = {MODEL_ID, 32'h00000000}; // R4
                                nxt_st.resp_left = RESP_WORD;
                                nxt_st.state     = SBC_RESP;
                            end
                        end
                        else if (st_ff.op[7:3] == OP_STD_CAL[7:3])
                        begin
                            // One store per reset: the new standard only acts after the next reset
                            if (!st_ff.std_locked && st_ff.args[15:8] <= SEL_MAX) // R19
                            begin
                                nxt_st.std_write  = 1'b1; // R6 R9
                                nxt_st.std_locked = 1'b1; // R9
                                nxt_st.std_sel    = st_ff.args[9:8]; // R6
                                nxt_st.std_chan   = st_ff.op[2:0];
                                nxt_st.std_value  = {st_ff.args[7:0], b}; // R5
                            end
                            nxt_st.resp      = {STD_DONE_BYTE, 40'h0000000000}; // R7
                            nxt_st.resp_left = RESP_ONE;
                            nxt_st.state     = SBC_RESP;
                        end
                        else if (st_ff.op[7:3] == OP_GAUGE_SPAN[7:3])
                        begin
                            expect_w  = {st_ff.args[7:0], b};
                            delta     = $signed({st_ff.last_raw[ch][15], st_ff.last_raw[ch]})
                                        - $signed({st_ff.zero[ch][15], st_ff.zero[ch]});
                            delta_abs = delta[16] ? 17'(-delta) : 17'(delta);
                            nxt_st.div_d   = (delta_abs[16] || delta_abs[15]) ? GAIN_SAT : delta_abs[15:0];
                            nxt_st.div_q   = {(expect_w[15] ? 16'(-expect_w) : expect_w), 8'h00};
                            nxt_st.div_neg = expect_w[15] ^ delta[16];
                            nxt_st.div_rem = 17'h00000;
                            nxt_st.div_cnt = 5'(DIV_STEPS); // R18
                            nxt_st.state   = SBC_DIV; // R15
                        end
                        else
                        begin
                            nxt_st.zero[ch]   = st_ff.args[39:24]; // R17
                            nxt_st.gain[ch]   = st_ff.args[23:8];
                            nxt_st.tare[ch]   = {st_ff.args[7:0], b};
                            nxt_st.cal_ok[ch] = 1'b1;
                        end
                    end
                end
            end
            SBC_DIV:
            begin
                // Bit-serial divide keeps the span path small; 24 steps fit easily in the time budget
                if (st_ff.div_cnt != 5'h00)
                begin
                    rem2 = {st_ff.div_rem[15:0], st_ff.div_q[23]};
                    nxt_st.div_q = {st_ff.div_q[22:0], 1'b0};
                    if (rem2 >= {1'b0, st_ff.div_d})
                    begin
                        rem2 = rem2 - {1'b0, st_ff.div_d};
                        nxt_st.div_q[0] = 1'b1;
                    end
                    nxt_st.div_rem = rem2;
                    nxt_st.div_cnt = st_ff.div_cnt - 5'h01;
                end
                else
                begin
                    qsat = (st_ff.div_q[23:15] != 9'h000) ? GAIN_SAT : st_ff.div_q[15:0];
                    nxt_st.gain[ch]   = st_ff.div_neg ? 16'(-qsat) : qsat; // R15
                    nxt_st.cal_ok[ch] = 1'b1;
                    nxt_st.state      = SBC_IDLE;
                end
            end
            SBC_RESP:
            begin
                if (resp_ack_in)
                begin
                    nxt_st.resp      = {st_ff.resp[39:0], 8'h00};
                    nxt_st.resp_left = st_ff.resp_left - 3'h1;
                    if (st_ff.resp_left == 3'h1)
                        nxt_st.state = SBC_IDLE;
                end
            end
        endcase
        nxt_st.ready = (nxt_st.state == SBC_IDLE) || (nxt_st.state == SBC_ARGS);
        nxt_st.resp_on = (nxt_st.state == SBC_RESP);
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff       <= '0; // R13
            st_ff.state <= SBC_IDLE;
            st_ff.ready <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end
    assign cmd_ready_out   = st_ff.ready;
    assign resp_valid_out  = st_ff.resp_on;
    assign resp_byte_out   = st_ff.resp[47:40];
    assign cj_req_out      = st_ff.cj_req;
    assign excite_out      = st_ff.excite;
    assign tc_valid_out    = st_ff.tc_valid;
    assign tc_chan_out     = st_ff.tc_chan;
    assign tc_volt_out     = st_ff.tc_volt;
    assign gauge_valid_out = st_ff.g_valid;
    assign gauge_chan_out  = st_ff.g_chan;
    assign gauge_data_out  = st_ff.g_data;
    assign std_write_out   = st_ff.std_write;
    assign std_sel_out     = st_ff.std_sel;
    assign std_chan_out    = st_ff.std_chan;
    assign std_value_out   = st_ff.std_value;
    // Busy time from the command's last byte until the interpreter is idle or answering
    logic [11:0] busy_cyc;
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            busy_cyc <= 12'h000;
        else if (st_ff.state == SBC_DIV)
            busy_cyc <= busy_cyc + 12'h001;
        else
            busy_cyc <= 12'h000;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);
    fw_version_a: assert property (cmd_valid_in && st_ff.state == SBC_ARGS && st_ff.op == OP_EXT_PREFIX
        && st_ff.need == 3'h1 && st_ff.args[7:0] == SUB_FIRMWARE && cmd_byte_in == EXT_TRAILER
        |=> resp_valid_out && resp_byte_out == FW_VERSION[15:8]) else $error("firmware high byte wrong"); // R1
    ref_temp_a: assert property (st_ff.state == SBC_IDLE && cmd_valid_in && cmd_byte_in == OP_REF_TEMP
        |=> resp_valid_out && resp_byte_out == $past(cj_temp_in[15:8])) else $error("temperature reply wrong"); // R2 R3
    model_id_a: assert property (resp_valid_out && st_ff.resp_left == RESP_WORD && st_ff.op == OP_EXT_PREFIX
        && resp_ack_in ##1 resp_valid_out |-> resp_byte_out == MODEL_ID[7:0] || resp_byte_out == FW_VERSION[7:0])
        else $error("second identity byte wrong"); // R4
    std_one_byte_a: assert property (std_write_out |-> resp_valid_out && st_ff.resp_left == RESP_ONE)
        else $error("calibration reply not one byte"); // R7
    std_sel_a: assert property (std_write_out |-> std_sel_out <= SEL_STD_OHM) else $error("bad selector stored"); // R6 R19
    std_once_a: assert property (std_write_out |-> !$past(st_ff.std_locked)) else $error("repeated store"); // R9
    excite_a: assert property (excite_out != 8'h00 |-> $past(scan_active_in) && excite_out[$past(scan_chan_in)]
        && $onehot(excite_out)) else $error("excitation on wrong channel"); // R12
    tc_comp_a: assert property (sample_valid_in && tc_mask_in[sample_chan_in]
        |=> tc_valid_out && tc_volt_out == $past(sample_raw_in) + $past(st_ff.comp[tc_type_in[sample_chan_in]]))
        else $error("compensation not added"); // R11
    cj_period_a: assert property (cj_req_out |=> !cj_req_out [*2]) else $error("cold junction request too often"); // R10
    exec_time_a: assert property (busy_cyc < 12'(EXEC_LIMIT_CYC)) else $error("command took too long"); // R18
    gauge_gate_a: assert property (gauge_valid_out |-> st_ff.cal_ok[gauge_chan_out]) else $error("uncalibrated gauge data"); // R13

    fw_read_c: cover property (resp_valid_out && st_ff.op == OP_EXT_PREFIX && resp_ack_in);
    std_cal_c: cover property (std_write_out ##[1:5] !resp_valid_out);
    span_c:    cover property (st_ff.state == SBC_DIV ##[1:30] st_ff.state == SBC_IDLE);
    tare_c:    cover property (gauge_valid_out && st_ff.tare[gauge_chan_out] != 16'h0000);
endmodule

// ==== sbc_host_model.sv ====
// Purpose: Host side of the reply handshake; takes each offered byte after a random wait.
// Assumes: Driven off the falling edge, like the rest of the bench.
// Notes:   Ack is a one-cycle pulse so a byte is never taken twice.
`timescale 1ns/1ps
module sbc_host_model (
    input  wire logic clk_in,
    input  wire logic resp_valid_in,
    output logic      resp_ack_out
);
    int wait_cnt = 0;
    initial resp_ack_out = 1'b0;
    always @(negedge clk_in)
    begin
        if (resp_ack_out || !resp_valid_in)
        begin
            resp_ack_out <= 1'b0;
            wait_cnt     <= $urandom_range(3);
        end
        else if (wait_cnt == 0)
            resp_ack_out <= 1'b1;
        else
            wait_cnt <= wait_cnt - 1;
    end
endmodule

// ==== sbc_pkg.sv ====
// Purpose: Shared constants and state types of the sensor board command interpreter.
// Assumes: Byte-wide command and response streams, eight channels, one core clock.
// Notes:   Opcodes that carry a channel use the low three bits for it.
package sbc_pkg;

    localparam int unsigned NUM_CHAN        = 8;
    localparam int unsigned NUM_TC_TYPES    = 9;
    localparam int unsigned CLK_FREQ_MHZ    = 100;
    localparam int unsigned EXEC_LIMIT_US   = 30;
    localparam int unsigned EXEC_LIMIT_CYC  = EXEC_LIMIT_US * CLK_FREQ_MHZ;
    localparam int unsigned CJ_PERIOD_DEF   = 50000;
    localparam int unsigned GAIN_FRAC       = 8;
    localparam int unsigned DIV_STEPS       = 24;

    localparam logic [7:0]  OP_EXT_PREFIX   = 8'hF0;
    localparam logic [7:0]  SUB_FIRMWARE    = 8'h05;
    localparam logic [7:0]  SUB_MODEL       = 8'h04;
    localparam logic [7:0]  EXT_TRAILER     = 8'h00;
    localparam logic [7:0]  OP_REF_TEMP     = 8'h40;
    localparam logic [7:0]  OP_STD_CAL      = 8'hE0;
    localparam logic [7:0]  OP_GAUGE_ZERO   = 8'hB0;
    localparam logic [7:0]  OP_GAUGE_SPAN   = 8'hD0;
    localparam logic [7:0]  OP_TARE         = 8'h70;
    localparam logic [7:0]  OP_CAL_READBACK = 8'h80;
    localparam logic [7:0]  OP_CAL_RESTORE  = 8'h90;

    localparam logic [2:0]  ARGS_EXT        = 3'h2;
    localparam logic [2:0]  ARGS_STD_CAL    = 3'h3;
    localparam logic [2:0]  ARGS_SPAN       = 3'h2;
    localparam logic [2:0]  ARGS_RESTORE    = 3'h6;
    localparam logic [2:0]  RESP_WORD       = 3'h2;
    localparam logic [2:0]  RESP_CAL_DATA   = 3'h6;
    localparam logic [2:0]  RESP_ONE        = 3'h1;
    localparam logic [7:0]  STD_DONE_BYTE   = 8'h00;

    localparam logic [1:0]  SEL_STD_5V      = 2'h0;
    localparam logic [1:0]  SEL_STD_500MV   = 2'h1;
    localparam logic [1:0]  SEL_STD_OHM     = 2'h2;
    localparam logic [7:0]  SEL_MAX         = 8'h02;

    localparam logic [15:0] GAIN_SAT        = 16'h7FFF;
    localparam logic [15:0] SEEBECK_DEF     = 16'h0028;

    typedef enum logic [1:0] {
        SBC_IDLE,
        SBC_ARGS,
        SBC_DIV,
        SBC_RESP
    } sbc_state_e;

    typedef struct packed {
        sbc_state_e             state;
        logic [2:0]             need;
        logic [7:0]             op;
        logic [39:0]            args;
        logic [47:0]            resp;
        logic [2:0]             resp_left;
        logic                   ready;
        logic                   resp_on;
        logic                   std_locked;
        logic                   std_write;
        logic [1:0]             std_sel;
        logic [2:0]             std_chan;
        logic [15:0]            std_value;
        logic [7:0][15:0]       zero;
        logic [7:0][15:0]       gain;
        logic [7:0][15:0]       tare;
        logic [7:0][15:0]       last_raw;
        logic [7:0]             cal_ok;
        logic [8:0][15:0]       comp;
        logic [15:0]            cj_timer;
        logic                   cj_req;
        logic [7:0]             excite;
        logic                   tc_valid;
        logic [2:0]             tc_chan;
        logic [15:0]            tc_volt;
        logic                   g_valid;
        logic [2:0]             g_chan;
        logic [15:0]            g_data;
        logic [23:0]            div_q;
        logic [16:0]            div_rem;
        logic [15:0]            div_d;
        logic [4:0]             div_cnt;
        logic                   div_neg;
    } sbc_state_s;

endpackage

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Host model acks replies; bench drives on the falling edge.
// Notes:   Expected bytes, samples and store requests queue up; watchers pop them.
`timescale 1ns/1ps
`define CHK(n, e, s) begin logic [31:0] ev_m, sv_m; ev_m = 32'(e); sv_m = 32'(s); checked++; \
    if (ev_m !== sv_m) begin err_total++; $display("ERROR %s exp %h got %h", n, ev_m, sv_m); end end
module tb_top;
    import sbc_pkg::*;
    localparam logic [15:0] FW = 16'h0123, MID = 16'h5A3C; // Arbitrary identity values
    logic clk = 0, rst_n = 0, cv = 0, cjv = 0, sa = 1, sv = 0, rdy, rv, ack, cjr, tv, gv, sw;
    logic [7:0] cb = 0, gm = 0, tm = 0, rb, ex;
    logic [7:0][3:0] tt = 0;
    logic [15:0] cj = 0, raw = 0, tvo, gd, sval;
    logic [2:0] sch = 0, smc = 0, tc, gc, sc;
    logic [1:0] ss;
    logic [7:0] rq[$];
    logic [19:0] dq[$];
    logic [20:0] sq[$];
    int err_total = 0, checked = 0, cyc = 0;
    always #5 clk = ~clk;
    sbc_core #(.FW_VERSION(FW), .MODEL_ID(MID), .CJ_PERIOD(16)) dut (.core_clk_in(clk), .reset_n_in(rst_n),
        .cmd_valid_in(cv), .cmd_byte_in(cb), .cmd_ready_out(rdy), .resp_valid_out(rv), .resp_byte_out(rb),
        .resp_ack_in(ack), .cj_temp_in(cj), .cj_valid_in(cjv), .cj_req_out(cjr), .gauge_mask_in(gm),
        .tc_mask_in(tm), .tc_type_in(tt), .scan_active_in(sa), .scan_chan_in(sch), .sample_valid_in(sv),
        .sample_chan_in(smc), .sample_raw_in(raw), .excite_out(ex), .tc_valid_out(tv), .tc_chan_out(tc),
        .tc_volt_out(tvo), .gauge_valid_out(gv), .gauge_chan_out(gc), .gauge_data_out(gd),
        .std_write_out(sw), .std_sel_out(ss), .std_chan_out(sc), .std_value_out(sval));
    sbc_host_model host (.clk_in(clk), .resp_valid_in(rv), .resp_ack_out(ack));
    task automatic results();
        $display("Counts: %0d checked, %0d mismatched", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // An empty queue pops as unknown, so a surplus output always mismatches
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000) begin err_total++; results(); end
        if (rv && ack) `CHK("resp_byte", rq.pop_front(), rb)
        if (gv) `CHK("gauge", dq.pop_front(), {1'b1, gc, gd})
        if (tv) `CHK("tc", dq.pop_front(), {1'b0, tc, tvo})
        if (sw) `CHK("std", sq.pop_front(), {ss, sc, sval})
    end
    task automatic tick(int n); repeat (n) @(negedge clk); endtask
    task automatic rst(); rst_n = 0; tick(6); rst_n = 1; tick(3); endtask
    task automatic sendb(logic [7:0] b);
        int n = 0;
        @(negedge clk);
        while (rdy !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        cv = 1; cb = b;
        @(negedge clk);
        cv = 0;
    endtask
    task automatic drain();
        int n = 0;
        while ((rq.size() != 0 || rv !== 1'b0) && n < 200) begin @(negedge clk); n++; end
    endtask
    task automatic pushw(logic [15:0] w); rq.push_back(w[15:8]); rq.push_back(w[7:0]); endtask
    task automatic smp(logic [2:0] ch, logic [15:0] r);
        @(negedge clk); sv = 1; smc = ch; raw = r;
        @(negedge clk); sv = 0;
    endtask
    task automatic gs(logic [15:0] r, logic [15:0] e, bit want);
        if (want) dq.push_back({1'b1, 3'h2, e});
        smp(3'h2, r);
    endtask
    task automatic stdcal(int s, logic [15:0] v);
        rq.push_back(STD_DONE_BYTE);
        sendb(OP_STD_CAL + 8'(s)); sendb(8'(s)); sendb(v[15:8]); sendb(v[7:0]); drain();
    endtask
    initial
    begin
        logic [15:0] v;
        logic signed [31:0] cmp;
        void'($urandom(32'h4E70C2C0));
        rst();
        pushw(FW); sendb(OP_EXT_PREFIX); sendb(SUB_FIRMWARE); sendb(EXT_TRAILER); drain();
        pushw(MID); sendb(OP_EXT_PREFIX); sendb(SUB_MODEL); sendb(EXT_TRAILER); drain();
        $display("Test identity done");
        cj = 16'($urandom_range(2000)) - 16'h03E8; tm = 8'h08; tt[3] = 4'($urandom_range(8));
        @(negedge clk); cjv = 1; @(negedge clk); cjv = 0;
        pushw(cj); sendb(OP_REF_TEMP); drain();
        cmp = ($signed(cj) * 32'sh28) >>> 8;
        v = 16'($urandom_range(20000));
        dq.push_back({1'b0, 3'h3, v + cmp[15:0]}); smp(3'h3, v);
        v = 0; while (cjr !== 1'b1 && v < 20) begin @(negedge clk); v++; end
        `CHK("cj_req", 1'b1, cjr)
        $display("Test temperature done");
        for (int s = 0; s < 4; s++)
        begin
            v = 16'($urandom); rst();
            if (s < 3) sq.push_back({2'(s), 3'(s), v});
            stdcal(s, v);
            if (s == 0) stdcal(1, v);
        end
        $display("Test standards done");
        gm = 8'h04; sch = 3'h2; tick(2);
        `CHK("excite", 8'h04, ex)
        sch = 3'h5; tick(2);
        `CHK("excite", 8'h00, ex)
        sch = 3'h2;
        gs(16'h0064, 0, 0); sendb(OP_GAUGE_ZERO + 8'h02);
        gs(16'h0164, 0, 0); sendb(OP_GAUGE_SPAN + 8'h02); sendb(8'h03); sendb(8'hE8); tick(30);
        gs(16'h0164, 16'h03E8, 1); sendb(OP_TARE + 8'h02);
        gs(16'h0164, 16'h0000, 1); gs(16'h0264, 16'h03E8, 1);
        pushw(16'h0064); pushw(16'h03E8); pushw(16'h03E8); sendb(OP_CAL_READBACK + 8'h02); drain();
        $display("Test gauge done");
        rst(); gs(16'h0164, 0, 0);
        sendb(OP_CAL_RESTORE + 8'h02); sendb(8'h00); sendb(8'h64);
        sendb(8'h03); sendb(8'hE8); sendb(8'h03); sendb(8'hE8);
        gs(16'h0164, 16'h0000, 1); gs(16'h0264, 16'h03E8, 1); tick(4);
        `CHK("left", 0, rq.size() + dq.size() + sq.size())
        $display("Test restore done");
        results();
    end
endmodule
